/* File: design/spc_map.svh */
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// clock-stop mode codes
`define SPC_STOP_NODLY 2'h2
`define SPC_STOP_DLY   2'h3

// default widths and depths
`define SPC_WORD_W     8
`define SPC_DIV_W      8
`define SPC_FIFO_D     8

// divider value for every slave setup: bit clock at half the cpu clock
`define SPC_SLV_DIV    8'h01

`endif

/* File: design/spc_pkg.sv */
package spc_pkg;

    typedef enum logic [1:0] {
        SPC_IDLE,
        SPC_LEAD,
        SPC_XFER,
        SPC_TRAIL
    } spc_state_t;

endpackage

/* File: design/spc_stream_if.sv */
`timescale 1ns/1ps
interface spc_stream_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: design/spc_fifo.sv */
`timescale 1ns/1ps
module spc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    spc_stream_if.snk wr_if,
    spc_stream_if.src rd_if
);
    import spc_pkg::*;

    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } spc_fifo_st_t;

    spc_fifo_st_t q;
    spc_fifo_st_t next_q;
    logic [W-1:0] mem [D];
    logic         push;
    logic         pop;

    assign wr_if.ready = (q.cnt != (AW+1)'(D));
    assign rd_if.valid = (q.cnt != '0);
    assign rd_if.data  = mem[q.rp];
    assign push        = wr_if.valid & wr_if.ready;
    assign pop         = rd_if.valid & rd_if.ready;

    always_comb
    begin
        next_q = q;
        if (push)
        begin
            next_q.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
        begin
            next_q.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
        if (push)
        begin
            mem[q.wp] <= wr_if.data;
        end
    end
endmodule

/* File: design/spc_srg.sv */
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_srg #(
    parameter int DW = `SPC_DIV_W
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    input  wire logic          srg_input_select_i,
    input  wire logic          ext_srg_clock_i,
    input  wire logic [DW-1:0] srg_divider_i,
    input  wire logic          run_i,
    input  wire logic          start_lo_i,
    output logic               level_o,
    output logic               rise_o,
    output logic               fall_o
);
    import spc_pkg::*;

    typedef struct packed {
        logic          ext_s1;
        logic          ext_s2;
        logic          ext_s3;
        logic          lvl;
        logic [DW:0]   cnt;
    } spc_srg_st_t;

    spc_srg_st_t q;
    spc_srg_st_t next_q;
    logic        tick;
    logic        odd_or_zero;
    logic [DW:0] hi_len;
    logic [DW:0] lo_len;
    logic [DW:0] len;
    logic        flip;

    // cpu clock or the rising edge of the external clock feeds the divider
    assign tick = srg_input_select_i ? 1'b1 : (q.ext_s2 & ~q.ext_s3); // R2
    assign odd_or_zero = srg_divider_i[0] | (srg_divider_i == '0);

    always_comb
    begin
        hi_len = odd_or_zero ? (DW+1)'((srg_divider_i + 1'b1) >> 1) // R4
                             : (DW+1)'(srg_divider_i >> 1) + 1'b1;
        lo_len = odd_or_zero ? (DW+1)'((srg_divider_i + 1'b1) >> 1) // R5
                             : (DW+1)'(srg_divider_i >> 1);
        // a zero divider cannot give half-periods: clamp to one input period
        if (hi_len == '0)
        begin
            hi_len = (DW+1)'(1);
        end
        if (lo_len == '0)
        begin
            lo_len = (DW+1)'(1);
        end
        len  = q.lvl ? hi_len : lo_len; // R3
        flip = run_i & tick & (q.cnt + 1'b1 >= len);
    end

    always_comb
    begin
        next_q        = q;
        next_q.ext_s1 = ext_srg_clock_i;
        next_q.ext_s2 = q.ext_s1;
        next_q.ext_s3 = q.ext_s2;
        if (!run_i)
        begin
            next_q.lvl = ~start_lo_i;
            next_q.cnt = '0;
        end
        else if (flip)
        begin
            next_q.lvl = ~q.lvl;
            next_q.cnt = '0;
        end
        else if (tick)
        begin
            next_q.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            q <= '{lvl: 1'b1, default: '0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign level_o = q.lvl;
    assign rise_o  = flip & ~q.lvl;
    assign fall_o  = flip & q.lvl;

    // helper: input periods counted within the current phase
    logic [DW+1:0] seen;
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !run_i || flip)
        begin
            seen <= '0;
        end
        else if (tick)
        begin
            seen <= seen + 1'b1;
        end
    end

    hi_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R4
        (fall_o && $stable(srg_divider_i)) |-> (seen + 1'b1 == hi_len))
        else $error("high phase length wrong");
    lo_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R5
        (rise_o && $stable(srg_divider_i)) |-> (seen + 1'b1 == lo_len))
        else $error("low phase length wrong");
    ext_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R2
        ((rise_o || fall_o) && !srg_input_select_i) |-> $rose(q.ext_s2))
        else $error("divider stepped without external edge");
    half_rate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // R1
        (fall_o && srg_input_select_i && srg_divider_i == `SPC_SLV_DIV)
        ##1 run_i |-> rise_o)
        else $error("slave divider setting not half rate");
endmodule

/* File: design/spc_clkstop_port.sv */
`timescale 1ns/1ps
`include "spc_map.svh"
// Overview of operation
// [R1] Slave setups use cpu clock input and divider 1: bit clock is half.
// [R2] Divider input select 1 picks cpu clock, 0 the external clock.
// [R3] Bit clock period is one plus divider input periods; a zero divider gives two input periods.
// [R4] High time: divider/2+1 when even, (divider+1)/2 when odd or zero.
// [R5] Low time: divider/2 when even, (divider+1)/2 when odd or zero.
// [R6] Frame-sync polarity 1; master drives inverted select, active low.
// [R7] Slave inverts active-low select on both frame-sync pins.
// [R8] Master: transmit clock and frame sync driven, receive ones inputs.
// [R9] Slave: all clock and frame-sync pins are inputs.
// [R10] Select goes low before the first rising clock of a transfer.
// [R11] Master lead: high time in mode 10b, full period in mode 11b.
// [R12] Master tail: full period in mode 10b, high time in mode 11b.
// [R13] Mode 10b launches transmit bits on falling clock edges.
// [R14] Mode 11b launches transmit bits on rising edges, half cycle early.
// [R15] Mode 11b samples receive data on falling clock edges.
// [R16] Data pin floats after the rising edge ending the last bit.
// [R17] Slave in mode 10b floats data pin when select returns high.
// [R18] Slave drives first bit a few cycles after select falls.
// [R19] Master bit clock toggles only in transfers, else rests idle.
module spc_clkstop_port #(
    parameter int WORD_W = `SPC_WORD_W,
    parameter int DIV_W  = `SPC_DIV_W,
    parameter int FIFO_D = `SPC_FIFO_D
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              srg_input_select_i,
    input  wire logic              ext_srg_clock_i,
    input  wire logic [DIV_W-1:0]  srg_divider_i,
    input  wire logic [1:0]        clock_stop_select_i,
    input  wire logic              tx_clock_polarity_i,
    input  wire logic              tx_fs_polarity_i,
    input  wire logic              rx_fs_polarity_i,
    input  wire logic              tx_clock_direction_i,
    input  wire logic              rx_clock_direction_i,
    input  wire logic              tx_fs_direction_i,
    input  wire logic              rx_fs_direction_i,
    input  wire logic              tx_valid_i,
    input  wire logic [WORD_W-1:0] tx_data_i,
    output logic                   tx_ready_o,
    output logic                   rx_valid_o,
    output logic [WORD_W-1:0]      rx_data_o,
    output logic                   busy_o,
    input  wire logic              tx_serial_clock_i,
    output logic                   tx_serial_clock_o,
    output logic                   tx_serial_clock_oe_n_o,
    input  wire logic              tx_frame_sync_i,
    output logic                   tx_frame_sync_o,
    output logic                   tx_frame_sync_oe_n_o,
    input  wire logic              rx_frame_sync_i,
    output logic                   tx_data_pin_o,
    output logic                   tx_data_pin_oe_n_o,
    input  wire logic              rx_data_pin_i
);
    import spc_pkg::*;

    localparam int CW = $clog2(WORD_W + 1);
    localparam logic [CW-1:0] NBITS = CW'(WORD_W);

    typedef struct packed {
        spc_state_t        st;
        logic [WORD_W-1:0] tx_sh;
        logic [WORD_W-1:0] rx_sh;
        logic [CW-1:0]     nsamp;
        logic              dx_oe;
        logic              tstep;
        logic              sel;
        logic              clk_s1;
        logic              clk_s2;
        logic              clk_s3;
        logic              fs_s1;
        logic              fs_s2;
        logic              rfs_s1;
        logic              rfs_s2;
        logic              dr_s1;
        logic              dr_s2;
        logic              clk_pin;
        logic              fs_pin;
        logic              dx_pin;
        logic              dx_oe_pin;
        logic              rx_vld;
        logic [WORD_W-1:0] rx_word;
    } spc_top_st_t;

    spc_top_st_t q;
    spc_top_st_t next_q;

    logic master;
    logic dly;
    logic m_lvl;
    logic m_rise;
    logic m_fall;
    logic s_clk;
    logic s_clk_d;
    logic ev_r;
    logic ev_f;
    logic launch;
    logic sample;
    logic s_sel_tx;
    logic s_sel_rx;
    logic pop;
    logic mask;

    spc_stream_if #(.W(WORD_W)) fifo_in ();
    spc_stream_if #(.W(WORD_W)) fifo_out ();

    assign fifo_in.valid = tx_valid_i;
    assign fifo_in.data  = tx_data_i;
    assign tx_ready_o    = fifo_in.ready;
    assign fifo_out.ready = pop;

    spc_fifo #(
        .W (WORD_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .wr_if     (fifo_in),
        .rd_if     (fifo_out)
    );

    // the divider only runs while a master transfer is in flight
    spc_srg #(
        .DW (DIV_W)
    ) u_srg (
        .clk_sys_i          (clk_sys_i),
        .rst_n_i            (rst_n_i),
        .srg_input_select_i (srg_input_select_i),
        .ext_srg_clock_i    (ext_srg_clock_i),
        .srg_divider_i      (srg_divider_i),
        .run_i              (master && q.st != SPC_IDLE), // R19
        .start_lo_i         (dly), // R11
        .level_o            (m_lvl),
        .rise_o             (m_rise),
        .fall_o             (m_fall)
    );

    // master needs both transmit clock and frame sync driven
    assign master = tx_clock_direction_i & tx_fs_direction_i; // R8 R9
    assign dly    = (clock_stop_select_i == `SPC_STOP_DLY);

    // clock seen by the slave, folded so that polarity 1 is the reference
    assign s_clk   = tx_clock_polarity_i ? q.clk_s2 : ~q.clk_s2;
    assign s_clk_d = tx_clock_polarity_i ? q.clk_s3 : ~q.clk_s3;

    // active-low select from an external master, inverted for inside use
    assign s_sel_tx = tx_fs_polarity_i ? ~q.fs_s2 : q.fs_s2; // R7
    assign s_sel_rx = rx_fs_polarity_i ? ~q.rfs_s2 : q.rfs_s2; // R7

    // rx pin lags by its sync: master half periods under 4 cycles read stale
    assign ev_r   = master ? m_rise : (s_clk & ~s_clk_d);
    assign ev_f   = master ? m_fall : (~s_clk & s_clk_d);
    assign launch = dly ? ev_r : ev_f; // R13 R14
    assign sample = dly ? ev_f : ev_r; // R15

    // clock pin rests at idle in lead and after the last rising edge
    assign mask = (q.st == SPC_IDLE) || (q.st == SPC_LEAD) ||
                  ((q.st == SPC_TRAIL) && (!dly || q.tstep)); // R11 R12 R19

    always_comb
    begin
        next_q        = q;
        pop           = 1'b0;
        next_q.rx_vld = 1'b0;
        next_q.clk_s1 = tx_serial_clock_i;
        next_q.clk_s2 = q.clk_s1;
        next_q.clk_s3 = q.clk_s2;
        next_q.fs_s1  = tx_frame_sync_i;
        next_q.fs_s2  = q.fs_s1;
        next_q.rfs_s1 = rx_frame_sync_i;
        next_q.rfs_s2 = q.rfs_s1;
        next_q.dr_s1  = rx_data_pin_i;
        next_q.dr_s2  = q.dr_s1;

        case (q.st)
            SPC_IDLE:
            begin
                next_q.nsamp = '0;
                next_q.tstep = 1'b0;
                if (master && fifo_out.valid)
                begin
                    pop          = 1'b1;
                    next_q.tx_sh = fifo_out.data;
                    next_q.sel   = 1'b1; // R10
                    next_q.st    = dly ? SPC_LEAD : SPC_XFER; // R11
                end
                else if (!master && s_sel_tx)
                begin
                    // an empty queue sends zeros rather than stalling
                    pop          = fifo_out.valid;
                    next_q.tx_sh = fifo_out.valid ? fifo_out.data : '0;
                    next_q.dx_oe = 1'b1; // R18
                    next_q.sel   = 1'b1;
                    next_q.st    = SPC_XFER;
                end
            end
            SPC_LEAD:
            begin
                // first rising edge is hidden; it launches bit one
                if (m_rise)
                begin
                    next_q.dx_oe = 1'b1; // R14
                    next_q.st    = SPC_XFER;
                end
            end
            SPC_XFER:
            begin
                if (launch)
                begin
                    if (q.nsamp == NBITS)
                    begin
                        next_q.dx_oe = 1'b0; // R16
                    end
                    else
                    begin
                        next_q.dx_oe = 1'b1;
                        if (q.nsamp != '0)
                        begin
                            next_q.tx_sh = q.tx_sh << 1; // R13 R14
                        end
                    end
                end
                if (sample && q.nsamp != NBITS && (master || s_sel_rx))
                begin
                    next_q.rx_sh = {q.rx_sh[WORD_W-2:0], q.dr_s2}; // R15
                    next_q.nsamp = q.nsamp + 1'b1;
                    if (q.nsamp + 1'b1 == NBITS)
                    begin
                        next_q.rx_vld  = 1'b1;
                        next_q.rx_word = {q.rx_sh[WORD_W-2:0], q.dr_s2};
                        if (master)
                        begin
                            next_q.st = SPC_TRAIL; // R12
                        end
                    end
                end
                if (!master && !s_sel_tx)
                begin
                    next_q.dx_oe = 1'b0; // R17
                    next_q.sel   = 1'b0;
                    next_q.st    = SPC_IDLE;
                end
            end
            SPC_TRAIL:
            begin
                // first edge floats data, second ends the select tail
                if (ev_r || ev_f)
                begin
                    if (!q.tstep)
                    begin
                        next_q.dx_oe = 1'b0; // R16
                        next_q.tstep = 1'b1;
                    end
                    else
                    begin
                        next_q.sel = 1'b0; // R12
                        next_q.st  = SPC_IDLE;
                    end
                end
            end
            default:
            begin
                next_q.st = SPC_IDLE;
            end
        endcase

        next_q.clk_pin = mask ? tx_clock_polarity_i
                              : (tx_clock_polarity_i ? m_lvl : ~m_lvl);
        next_q.fs_pin    = tx_fs_polarity_i ? ~q.sel : q.sel; // R6
        next_q.dx_pin    = q.tx_sh[WORD_W-1];
        next_q.dx_oe_pin = q.dx_oe;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            q <= '{st: SPC_IDLE, clk_pin: 1'b1, fs_pin: 1'b1,
                   clk_s1: 1'b1, clk_s2: 1'b1, clk_s3: 1'b1,
                   fs_s1: 1'b1, fs_s2: 1'b1, rfs_s1: 1'b1, rfs_s2: 1'b1,
                   default: '0};
        end
        else
        begin
            q <= next_q;
        end
    end

    // receive clock and receive sync are never driven in clock-stop use
    assign tx_serial_clock_o      = q.clk_pin;
    assign tx_serial_clock_oe_n_o = ~master; // R8 R9
    assign tx_frame_sync_o        = q.fs_pin;
    assign tx_frame_sync_oe_n_o   = ~master; // R8 R9
    assign tx_data_pin_o          = q.dx_pin;
    assign tx_data_pin_oe_n_o     = ~q.dx_oe_pin;
    assign rx_valid_o             = q.rx_vld;
    assign rx_data_o              = q.rx_word;
    assign busy_o                 = (q.st != SPC_IDLE);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sel_active_low_a: assert property ( // R6
        (master && tx_fs_polarity_i && q.sel) |=> !tx_frame_sync_o)
        else $error("master select not driven low");
    slave_invert_a: assert property ( // R7
        (!master && q.st == SPC_IDLE && tx_fs_polarity_i && !q.fs_s2)
        |=> q.st == SPC_XFER)
        else $error("slave did not start on low select");
    clk_rest_a: assert property ( // R19
        (q.st == SPC_IDLE && $stable(tx_clock_polarity_i))
        |=> tx_serial_clock_o == tx_clock_polarity_i)
        else $error("bit clock not at rest between transfers");
    sel_before_rise_a: assert property ( // R10
        (master && m_rise) |-> q.sel)
        else $error("clock rose with select inactive");
    lead_hidden_a: assert property ( // R11
        (q.st == SPC_LEAD && $stable(tx_clock_polarity_i))
        |=> tx_serial_clock_o == tx_clock_polarity_i)
        else $error("clock moved during select lead");
    tail_select_a: assert property ( // R12
        (master && q.st == SPC_TRAIL) |=> q.sel || q.st == SPC_IDLE)
        else $error("select released early in tail");
    launch_fall_a: assert property ( // R13
        (master && !dly && q.st == SPC_XFER && m_fall
         && q.nsamp != '0 && q.nsamp != NBITS)
        |=> q.tx_sh == ($past(q.tx_sh) << 1))
        else $error("mode 10b bit not launched on fall");
    launch_rise_a: assert property ( // R14
        (master && dly && q.st == SPC_XFER && m_rise
         && q.nsamp != '0 && q.nsamp != NBITS)
        |=> q.tx_sh == ($past(q.tx_sh) << 1))
        else $error("mode 11b bit not launched on rise");
    sample_fall_a: assert property ( // R15
        (master && dly && q.st == SPC_XFER && m_fall && q.nsamp != NBITS)
        |=> q.nsamp == $past(q.nsamp) + 1'b1)
        else $error("mode 11b receive not sampled on fall");
    tail_float_a: assert property ( // R16
        (q.st == SPC_TRAIL && q.tstep) |=> tx_data_pin_oe_n_o)
        else $error("data pin still driven after last bit");
    slave_float_a: assert property ( // R17
        (!master && q.st == SPC_XFER && !s_sel_tx) |=> ##1 tx_data_pin_oe_n_o)
        else $error("slave data pin not released on select high");
    slave_first_a: assert property ( // R18
        (!master && q.st == SPC_IDLE && s_sel_tx) |=> ##1 !tx_data_pin_oe_n_o)
        else $error("slave first bit not driven");

    cover_m10_c: cover property (
        master && !dly && q.st == SPC_TRAIL ##[1:1000] q.st == SPC_IDLE);
    cover_m11_c: cover property (
        master && dly && q.st == SPC_TRAIL ##[1:1000] q.st == SPC_IDLE);
    cover_slave_c: cover property (!master && rx_valid_o);
endmodule

/* File: dv/spc_peer_model.sv */
`timescale 1ns/1ps
module spc_peer_model (
    input  wire logic       sclk_i,
    input  wire logic       sel_n_i,
    input  wire logic       mosi_i,
    input  wire logic       dly_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic [7:0]      got_o
);
    int n;

    initial miso_o = 1'b1;
    always @(negedge sel_n_i)
    begin
        n = 0;
        if (dly_i)
            miso_o = reply_i[7];
    end
    // samples on rises when undelayed, on falls when delayed
    always @(sclk_i)
        if (sel_n_i === 1'b0)
        begin
            if (sclk_i ^ dly_i)
            begin
                got_o = {got_o[6:0], mosi_i};
                n = n + 1;
            end
            else if (n < 8)
                miso_o = reply_i[3'(7 - n)];
        end
    // the released line has no pull, so it shows the opposite bit
    always @(posedge sel_n_i)
        miso_o = ~miso_o;
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cpu = 1'b1;
    logic        ext = 1'b0;
    logic [7:0]  div = 8'h03;
    logic [1:0]  mode = 2'h2;
    logic        mst = 1'b1;
    logic        tx_valid = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    logic        tb_fs = 1'b1;
    logic        tb_sc = 1'b1;
    logic [7:0]  reply = 8'hA5;
    logic [31:0] seed = 32'hBF75579A;
    logic        pc = 1'b1, ps = 1'b1, pd = 1'b0, poe = 1'b1, dl = 1'b0;
    logic        dly = 1'b0;
    logic        rdy, rxv, busy, sc_o, sc_oe, fs_o, fs_oe, d_o, d_oe, miso;
    logic [7:0]  rxd, got;
    int          miscompares = 0, comparisons = 0, cyc = 0, stalls = 0;
    int          hh, ll, tt, tol, hi, lo, nfall, rise_at, k;
    logic [7:0]  sent[$], exp_rx[$];
    wire logic   sc_w = sc_oe ? tb_sc : sc_o;
    wire logic   fs_w = fs_oe ? tb_fs : fs_o;
    wire logic   dw = d_oe ? ~dl : d_o;

    spc_clkstop_port DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .srg_input_select_i(cpu), .ext_srg_clock_i(ext),
        .srg_divider_i(div), .clock_stop_select_i(mode),
        .tx_clock_polarity_i(1'b1), .tx_fs_polarity_i(1'b1),
        .rx_fs_polarity_i(1'b1), .tx_clock_direction_i(mst),
        .rx_clock_direction_i(1'b0), .tx_fs_direction_i(mst),
        .rx_fs_direction_i(1'b0), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(rdy), .rx_valid_o(rxv),
        .rx_data_o(rxd), .busy_o(busy), .tx_serial_clock_i(sc_w),
        .tx_serial_clock_o(sc_o), .tx_serial_clock_oe_n_o(sc_oe),
        .tx_frame_sync_i(fs_w), .tx_frame_sync_o(fs_o),
        .tx_frame_sync_oe_n_o(fs_oe), .rx_frame_sync_i(fs_w),
        .tx_data_pin_o(d_o), .tx_data_pin_oe_n_o(d_oe),
        .rx_data_pin_i(miso));
    spc_peer_model PEER (.sclk_i(sc_w), .sel_n_i(fs_w), .mosi_i(dw),
        .dly_i(dly), .reply_i(reply), .miso_o(miso), .got_o(got));

    always #5 clk_sys_i = ~clk_sys_i;
    initial
    begin
        #3;
        forever #15 ext = ~ext;
    end
    always @(posedge clk_sys_i)
        if (d_oe === 1'b0)
            dl <= d_o;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic bit near(input int a, input int b);
        return (a > b ? a - b : b - a) <= tol;
    endfunction
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok)
        begin
            miscompares++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // external input is 3 cpu cycles a period; its first tick may be 2 early
    task automatic setup(input logic [1:0] m, input int d, input logic c);
        int s;
        s = c ? 1 : 3;
        mode = m;
        div = 8'(d);
        cpu = c;
        dly = (m == 2'h3);
        hh = (d % 2 == 0 ? d / 2 + 1 : (d + 1) / 2) * s;
        ll = (d % 2 == 0 ? d / 2 : (d + 1) / 2) * s;
        tt = (1 + d) * s;
        tol = c ? 0 : 2;
    endtask
    task automatic push(input logic [7:0] w);
        tx_valid = 1'b1;
        tx_data = w;
        for (k = 0; rdy !== 1'b1; k++)
            @(negedge clk_sys_i);
        stalls += k;
        @(negedge clk_sys_i);
        sent.push_back(w);
    endtask
    task automatic drain();
        tx_valid = 1'b0;
        for (k = 0; k < 4000 && (sent.size() != 0 || busy !== 1'b0); k++)
            @(negedge clk_sys_i);
        check(sent.size() == 0, "transfers unfinished");
    endtask

    always @(negedge clk_sys_i)
    begin
        if (++cyc > 60000)
        begin
            miscompares++;
            summarize();
        end
        if (rxv === 1'b1)
            check(exp_rx.size() != 0 && rxd === exp_rx.pop_front(),
                "rx");
        if (rst_n_i === 1'b1 && mst === 1'b1)
        begin
            if (ps === 1'b1 && fs_o === 1'b0)
            begin
                hi = 0;
                nfall = 0;
                exp_rx.push_back(reply);
            end
            if (fs_o === 1'b1)
                check(sc_o === 1'b1, "clock moved while idle");
            if (pc === 1'b1 && sc_o === 1'b0 && fs_o === 1'b0)
            begin
                check(near(hi, nfall == 0 && dly ? tt : hh), "high");
                nfall++;
                hi = 0;
            end
            if (pc === 1'b0 && sc_o === 1'b1)
            begin
                check(near(lo, ll), "low");
                lo = 0;
                rise_at = cyc;
            end
            if (poe === 1'b0 && d_oe === 1'b0 && d_o !== pd)
                check(dly ? pc === 1'b0 && sc_o === 1'b1 :
                    pc === 1'b1 && sc_o === 1'b0, "launch edge");
            if (poe === 1'b0 && d_oe === 1'b1)
                check(near(cyc - rise_at, dly ? 0 : hh), "release");
            if (ps === 1'b0 && fs_o === 1'b1)
            begin
                check(near(cyc - rise_at, dly ? hh : tt), "tail");
                check(sent.size() != 0 && got === sent.pop_front(),
                    "mosi");
                reply = rnd();
            end
            if (fs_o === 1'b0 && sc_o === 1'b1)
                hi++;
            if (fs_o === 1'b0 && sc_o === 1'b0)
                lo++;
        end
        pc = sc_o;
        ps = fs_o;
        pd = d_o;
        poe = d_oe;
    end

    initial
    begin
        setup(2'h2, 3, 1'b1);
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        check(d_oe === 1'b1 && fs_o === 1'b1 && rdy === 1'b1, "reset");
        check(sc_oe === 1'b0 && fs_oe === 1'b0, "master pins");
        for (int i = 0; i < 24; i++)
        begin
            // cpu-fed runs keep four cycles a half period for the rx sync
            setup(2'(rnd()), (i % 6 != 5 ? 7 : 3) + int'(rnd() % 7),
                  i % 6 != 5);
            for (int j = 0; j <= rnd() % 3; j++)
                push(8'(rnd()));
            drain();
        end
        setup(2'h3, 9, 1'b1);
        stalls = 0;
        for (int j = 0; j < 10; j++)
            push(8'(rnd()));
        check(stalls > 0, "full fifo accepted a word");
        drain();
        setup(2'h2, 1, 1'b1);
        mst = 1'b0;
        push(8'hC3);
        tx_valid = 1'b0;
        sent.delete();
        repeat (2) @(negedge clk_sys_i);
        check(sc_oe === 1'b1 && fs_oe === 1'b1, "slave pins");
        tb_fs = 1'b0;
        exp_rx.push_back(reply);
        for (k = 0; k < 8 && d_oe !== 1'b0; k++)
            @(negedge clk_sys_i);
        check(k <= 5 && d_o === 1'b1, "slave first bit");
        // four cpu cycles a half period leave room for the pin syncs
        repeat (16)
        begin
            repeat (4) @(negedge clk_sys_i);
            tb_sc = ~tb_sc;
        end
        repeat (4) @(negedge clk_sys_i);
        check(got === 8'hC3, "slave mosi");
        tb_fs = 1'b1;
        for (k = 0; k < 8 && d_oe !== 1'b1; k++)
            @(negedge clk_sys_i);
        check(k <= 5, "slave release");
        summarize();
    end
endmodule
